//--- core/cpr_readout.sv
/*
 * Read-out core of a cascadable configuration memory: array, address and
 * bit counters, data pins, chain enable, power-up hold, standby flag.
 * Assumes configuration clock, reset/output-enable and device select are
 * synchronous to the system clock and slower than half of it.
 */
// How it works
// - launch instruction pulses the configuration strobe low for 320 ns.
// - instruction code EE hex is the launch-configuration instruction.
// - each rising configuration clock edge while active advances the bit and address counters, or only the address counter in parallel mode.
// - enabled and selected, the counters run, data drives, chain enable stays high.
// - edge after the last bit: chain enable low, data floats, address back to zero and held there.
// - last address is all ones; stepping past it wraps to zero.
// - a downstream part drives data once its select input sees low.
// - reset/output-enable low clears and holds counters, data floats, chain high.
// - device select high puts the part in standby.
// - device select high floats data regardless of reset/output-enable.
// - after power-up the reset/output-enable line is pulled low for 1 ms.
// - reset/output-enable is always active low, no polarity option.
// - serial or parallel is a user control bit, serial by default.
// - parallel mode gives a byte per clock on eight data pins.
// - select tied low never enters standby; data still floats when held in reset or after the last bit.
// - user control bit is written apart from the array contents.
`timescale 1ns/10ps
`default_nettype none

module cpr_readout #(
	parameter int unsigned                POWERUP_HOLD_CYCLES = cpr_pkg::POWERUP_CYCLES,
	// terminal count; only a bench shortens it, so that a stream end is reachable
	parameter logic [cpr_pkg::ADDR_W-1:0] LAST_ADDR           = cpr_pkg::LAST_ADDRESS
) (
	// system
	input  wire logic                        clock,
	input  wire logic                        sys_rst,
	input  wire logic                        clkEn,
	// configuration side
	input  wire logic                        config_clock,
	input  wire logic                        resetOeN,
	input  wire logic                        chipSelectN,
	output logic [7:0]                       dataOut,
	output logic [7:0]                       dataOe,
	output logic                             chain_enable_out_n,
	output logic                             resetOeOut,
	output logic                             resetOeOe,
	output logic                             fpga_config_strobe_n,
	output logic                             standby,
	// instruction and programming side
	input  wire logic [7:0]                  instrCode,
	input  wire logic                        instrUpdate,
	input  wire logic                        userCtrlWrite,
	input  wire logic                        userCtrlParallel,
	input  wire logic                        progWrite,
	input  wire logic [cpr_pkg::ADDR_W-1:0]  progAddr,
	input  wire logic [7:0]                  progData
);
	import cpr_pkg::*;

	logic [7:0]              mem [0:MEM_DEPTH-1];
	cpr_rd_state_t           state_q;
	cpr_rd_state_t           state_d;
	logic [ADDR_W-1:0]       addr_q;
	logic [BIT_W-1:0]        bit_q;
	logic                    cfgClkPrev_q;
	logic                    cfgRise;
	logic                    parallelMode;
	logic                    strobeN;
	logic [POWERUP_CNT_W-1:0] holdCnt_q;
	logic                    holdLow_q;
	logic [7:0]              dataOut_q;
	logic [7:0]              dataOe_q;
	logic                    chainN_q;
	logic                    standby_q;
	logic                    strobeOut_q;
	logic [7:0]              curByte;
	logic                    enabled;

	// final step of the stream depends on the output width
	function automatic logic atLastStep(input logic [ADDR_W-1:0] a, input logic [BIT_W-1:0] b,
		input logic par);
		atLastStep = (a == LAST_ADDR) && (par || b == LAST_BIT);
	endfunction

	// ----------------------------------------------------------------
	// instruction control
	// ----------------------------------------------------------------
	cpr_jtag_ctl u_jtag (
		.clock                (clock),
		.sys_rst              (sys_rst),
		.clkEn                (clkEn),
		.instrCode            (instrCode),
		.instrUpdate          (instrUpdate),
		.userCtrlWrite        (userCtrlWrite),
		.userCtrlParallel     (userCtrlParallel),
		.fpga_config_strobe_n (strobeN),
		.parallelMode         (parallelMode)
	);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			strobeOut_q <= 1'b1;
		end else if (clkEn) begin
			strobeOut_q <= strobeN;
		end
	end

	// ----------------------------------------------------------------
	// array programming
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (clkEn && progWrite) begin
			mem[progAddr] <= progData;
		end
	end

	// ----------------------------------------------------------------
	// power-up hold
	// ----------------------------------------------------------------
	// the pin is open drain: we only ever pull it low, a resistor lifts it
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			holdCnt_q <= '0;
			holdLow_q <= 1'b1;
		end else if (clkEn && holdLow_q) begin
			if (holdCnt_q == POWERUP_CNT_W'(POWERUP_HOLD_CYCLES - 1)) begin
				holdLow_q <= 1'b0;
			end else begin
				holdCnt_q <= holdCnt_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// clock edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfgClkPrev_q <= 1'b0;
		end else if (clkEn) begin
			cfgClkPrev_q <= config_clock;
		end
	end

	// active-low only: no polarity select exists on purpose
	// our own power-up pull also holds the counters cleared
	assign enabled = resetOeN && !holdLow_q;
	// an edge only counts once the part is ready to give data
	assign cfgRise = config_clock && !cfgClkPrev_q;

	// ----------------------------------------------------------------
	// read-out state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			RD_HELD, RD_STANDBY: begin
				state_d = RD_HELD;
			end
			RD_ACTIVE: begin
				if (cfgRise && atLastStep(addr_q, bit_q, parallelMode)) begin
					state_d = RD_DONE;
				end
			end
			RD_DONE: begin
				state_d = RD_DONE;
			end
			default: begin
				state_d = RD_HELD;
			end
		endcase
		if (chipSelectN) begin
			state_d = RD_STANDBY;
		end else if (!enabled) begin
			state_d = RD_HELD;
		end else if (state_q == RD_HELD || state_q == RD_STANDBY) begin
			state_d = RD_ACTIVE;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q <= RD_HELD;
		end else if (clkEn) begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// address and bit counters
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			addr_q <= ADDR_RESET;
			bit_q  <= BIT_RESET;
		end else if (clkEn) begin
			if (chipSelectN || !enabled) begin
				addr_q <= ADDR_RESET;
				bit_q  <= BIT_RESET;
			end else if (state_q == RD_ACTIVE && cfgRise) begin
				if (parallelMode || bit_q == LAST_BIT) begin
					// explicit wrap, so a shortened terminal count still returns to zero
					addr_q <= atLastStep(addr_q, bit_q, parallelMode) ? ADDR_RESET : addr_q + 1'b1;
					bit_q  <= BIT_RESET;
				end else begin
					bit_q  <= bit_q + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// output pins
	// ----------------------------------------------------------------
	// registered from the counters, so data follows an advancing edge by a
	// couple of system cycles and then holds until the next one
	assign curByte = mem[addr_q];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			dataOut_q <= 8'h00;
			dataOe_q  <= 8'h00;
			chainN_q  <= 1'b1;
			standby_q <= 1'b0;
		end else if (clkEn) begin
			standby_q <= (state_q == RD_STANDBY);
			chainN_q  <= (state_q != RD_DONE);
			if (parallelMode) begin
				dataOut_q <= curByte;
			end else begin
				dataOut_q <= {7'h00, curByte[LAST_BIT - bit_q]};
			end
			if (state_q == RD_ACTIVE) begin
				dataOe_q <= parallelMode ? 8'hFF : 8'h01;
			end else begin
				dataOe_q <= 8'h00;
			end
		end
	end

	assign dataOut              = dataOut_q;
	assign dataOe               = dataOe_q;
	assign chain_enable_out_n   = chainN_q;
	assign resetOeOut           = 1'b0;
	assign resetOeOe            = holdLow_q;
	assign fpga_config_strobe_n = strobeOut_q;
	assign standby              = standby_q;

endmodule // cpr_readout
`default_nettype wire

//--- core/cpr_pkg.sv
/*
 * Shared constants and types for the configuration memory read-out block.
 * Assumes a 25 MHz system clock; every other pin is sampled on that clock.
 */
package cpr_pkg;

	// ----------------------------------------------------------------
	// array geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W    = 19;
	localparam int unsigned MEM_DEPTH = 1 << ADDR_W;
	localparam int unsigned BIT_W     = 3;
	localparam logic [ADDR_W-1:0] LAST_ADDRESS = {ADDR_W{1'b1}};
	localparam logic [BIT_W-1:0]  LAST_BIT     = 3'h7;
	localparam logic [ADDR_W-1:0] ADDR_RESET   = 19'h00000;
	localparam logic [BIT_W-1:0]  BIT_RESET    = 3'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS    = 40;
	localparam int unsigned STROBE_MIN_NS    = 300;
	localparam int unsigned STROBE_MAX_NS    = 500;
	localparam int unsigned STROBE_CYCLES    = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POWERUP_HOLD_US  = 1000;
	localparam int unsigned POWERUP_CYCLES   = (POWERUP_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STROBE_CNT_W     = 4;
	localparam int unsigned POWERUP_CNT_W    = 16;

	// ----------------------------------------------------------------
	// instruction codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] INSTR_LAUNCH_CONFIG = 8'hEE;
	localparam logic       PARALLEL_RESET      = 1'b0;

	typedef enum logic [1:0] {
		RD_HELD    = 2'b00,
		RD_ACTIVE  = 2'b01,
		RD_DONE    = 2'b10,
		RD_STANDBY = 2'b11
	} cpr_rd_state_t;

endpackage

//--- core/cpr_jtag_ctl.sv
/*
 * Instruction-side control: launch-configuration strobe and the
 * serial/parallel user control bit.
 * Assumes a TAP outside hands over each updated instruction and each
 * user control write as one-cycle strobes on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module cpr_jtag_ctl (
	// system
	input  wire logic                        clock,
	input  wire logic                        sys_rst,
	input  wire logic                        clkEn,
	// instruction handover
	input  wire logic [7:0]                  instrCode,
	input  wire logic                        instrUpdate,
	input  wire logic                        userCtrlWrite,
	input  wire logic                        userCtrlParallel,
	// results
	output logic                             fpga_config_strobe_n,
	output logic                             parallelMode
);
	import cpr_pkg::*;

	logic [STROBE_CNT_W-1:0] strobeCnt_q;
	logic                    strobeN_q;
	logic                    parallel_q;

	// ----------------------------------------------------------------
	// launch strobe
	// ----------------------------------------------------------------
	// a relaunch during a pulse restarts it, so the low time never shortens
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			strobeCnt_q <= '0;
			strobeN_q   <= 1'b1;
		end else if (clkEn) begin
			if (instrUpdate && instrCode == INSTR_LAUNCH_CONFIG) begin
				strobeCnt_q <= STROBE_CNT_W'(STROBE_CYCLES - 1);
				strobeN_q   <= 1'b0;
			end else if (strobeCnt_q != '0) begin
				strobeCnt_q <= strobeCnt_q - 1'b1;
			end else begin
				strobeN_q   <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// user control bit
	// ----------------------------------------------------------------
	// kept apart from the array, so setting it never touches stored data
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			parallel_q <= PARALLEL_RESET;
		end else if (clkEn && userCtrlWrite) begin
			parallel_q <= userCtrlParallel;
		end
	end

	assign fpga_config_strobe_n = strobeN_q;
	assign parallelMode         = parallel_q;

endmodule // cpr_jtag_ctl
`default_nettype wire

//--- verif/cpr_readout_checker.sv
/* concurrent checks on the read-out ports
   bound into cpr_readout from the bench top file */
`timescale 1ns/10ps
`default_nettype none

module cpr_readout_checker #(
	parameter int unsigned POWERUP_HOLD_CYCLES = 20
) (
	// system
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       clkEn,
	// pins
	input wire logic       config_clock,
	input wire logic       resetOeN,
	input wire logic       chipSelectN,
	input wire logic [7:0] dataOut,
	input wire logic [7:0] dataOe,
	input wire logic       chain_enable_out_n,
	input wire logic       resetOeOut,
	input wire logic       resetOeOe,
	input wire logic       fpga_config_strobe_n,
	input wire logic       standby,
	input wire logic [7:0] instrCode,
	input wire logic       instrUpdate
);
	import cpr_pkg::*;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic [15:0] relCnt_q;
	// a frozen block ignores the handover
	wire logic   launchReq = clkEn && instrUpdate && instrCode == INSTR_LAUNCH_CONFIG;
	always_ff @(posedge clock) begin
		if (sys_rst)
			relCnt_q <= 16'h0000;
		else if (relCnt_q != 16'hFFFF)
			relCnt_q <= relCnt_q + 16'h0001;
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	sequence s_launch;
		launchReq;
	endsequence
	sequence s_pulse;
		!fpga_config_strobe_n [*8] ##1 fpga_config_strobe_n;
	endsequence
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_strobe_pulse: assert property (s_launch |-> ##2 s_pulse)
		else $error("strobe pulse length wrong");
	a_strobe_cause: assert property ($fell(fpga_config_strobe_n) |-> $past(launchReq, 2))
		else $error("strobe without launch code");
	// one cycle of slack before the hold end, two cycles after it
	a_hold_low: assert property (relCnt_q < POWERUP_HOLD_CYCLES - 1 |-> resetOeOe && !resetOeOut)
		else $error("power-up hold released early");
	a_hold_end: assert property (relCnt_q > POWERUP_HOLD_CYCLES + 1 |-> !resetOeOe)
		else $error("power-up hold too long");
	a_reset_float: assert property (!resetOeN ##1 !resetOeN |-> ##1 dataOe == 8'h00 && chain_enable_out_n)
		else $error("data driven while held reset");
	a_select_float: assert property (chipSelectN ##1 chipSelectN |-> ##1 dataOe == 8'h00 && standby)
		else $error("deselected part not in standby");
	a_select_awake: assert property (!chipSelectN [*3] |-> !standby)
		else $error("standby while selected");
	a_chain_stands: assert property (!chain_enable_out_n && resetOeN && !chipSelectN |=> !chain_enable_out_n)
		else $error("chain enable released");
	a_done_float: assert property ($fell(chain_enable_out_n) |-> dataOe == 8'h00)
		else $error("data driven after last bit");
	a_data_step: assert property (dataOe != 8'h00 && $past(dataOe) != 8'h00 && $changed(dataOut)
		|-> $past(config_clock, 2) && !$past(config_clock, 3))
		else $error("data changed off a clock edge");
	a_serial_bits: assert property (dataOe == 8'h01 |-> dataOut[7:1] == 7'h00)
		else $error("serial upper bits not zero");
endmodule // cpr_readout_checker
`default_nettype wire

//--- verif/cpr_fpga_model.sv
/* logic-device side: configuration clock master and init line
   assumes the bench calls step and setInit from its main sequence */
`timescale 1ns/10ps
`default_nettype none

module cpr_fpga_model (
	// system
	input  wire logic clock,
	// read-out pins
	input  wire logic resetOeOut,
	input  wire logic resetOeOe,
	output logic      config_clock,
	output logic      resetOeN
);
	// mode pins all low: serial master
	localparam logic [2:0] FPGA_MODE = 3'h0;
	logic initN_q;
	// open-drain line with pull-up, init drives it to clear counters
	assign resetOeN = !(resetOeOe && !resetOeOut) && initN_q;
	initial begin
		config_clock = 1'b0;
		initN_q = 1'b0;
	end
	task automatic setInit(input logic v);
		@(negedge clock);
		initN_q = v;
	endtask
	// clock stands low between steps, 3 cycles high and 3 low
	task automatic step();
		if (FPGA_MODE == 3'h0) begin
			@(negedge clock);
			config_clock = 1'b1;
			repeat (3) @(negedge clock);
			config_clock = 1'b0;
			repeat (3) @(negedge clock);
		end
	endtask
endmodule // cpr_fpga_model
`default_nettype wire

//--- verif/cpr_readout_test.sv
/* self-checking bench for cpr_readout
   assumes package, design, checker and model are compiled first */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module cpr_readout_test;
	import cpr_pkg::*;
	localparam int unsigned HOLD = 20;
	localparam logic [ADDR_W-1:0] LAST = 19'h00003;
	logic              clock, sys_rst, clkEn, chipSelectN, instrUpdate;
	logic              userCtrlWrite, userCtrlParallel, progWrite;
	logic [7:0]        instrCode, progData, dataOut, dataOe;
	logic [ADDR_W-1:0] progAddr;
	logic              config_clock, resetOeN, chain_enable_out_n;
	logic              resetOeOut, resetOeOe, fpga_config_strobe_n, standby;
	int                n_fail = 0;
	int                samples_checked = 0;
	logic [7:0]        mem [4] = '{8'hA5, 8'h3C, 8'h96, 8'h0F};

	cpr_readout #(.POWERUP_HOLD_CYCLES(HOLD), .LAST_ADDR(LAST)) u_cpr_readout (.clock, .sys_rst, .clkEn, .config_clock,
		.resetOeN, .chipSelectN, .dataOut, .dataOe, .chain_enable_out_n, .resetOeOut, .resetOeOe,
		.fpga_config_strobe_n, .standby, .instrCode, .instrUpdate, .userCtrlWrite, .userCtrlParallel,
		.progWrite, .progAddr, .progData);
	cpr_fpga_model u_cpr_fpga_model (.clock, .resetOeOut, .resetOeOe, .config_clock, .resetOeN);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic prog(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(negedge clock);
		progWrite = 1'b1;
		progAddr = a;
		progData = d;
		@(negedge clock);
		progWrite = 1'b0;
	endtask
	task automatic t_powerup();
		int n;
		u_cpr_fpga_model.setInit(1'b1);
		repeat (4) @(negedge clock);
		`CHK(resetOeN, 1'b0)
		n = 5;
		while (resetOeOe === 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		`CHK(n >= HOLD && n < 100, 1'b1)
		if (n >= 100)
			results();
		`CHK(resetOeN, 1'b1)
		u_cpr_fpga_model.setInit(1'b0);
	endtask
	task automatic t_serial();
		u_cpr_fpga_model.setInit(1'b1);
		repeat (3) @(negedge clock);
		for (int i = 0; i < 16; i++) begin
			if (i > 0)
				u_cpr_fpga_model.step();
			`CHK(dataOe, 8'h01)
			`CHK(dataOut[0], mem[i / 8][7 - i % 8])
		end
		`CHK(chain_enable_out_n, 1'b1)
	endtask
	task automatic t_parallel();
		u_cpr_fpga_model.setInit(1'b0);
		userCtrlParallel = 1'b1;
		userCtrlWrite = 1'b1;
		@(negedge clock);
		userCtrlWrite = 1'b0;
		repeat (2) @(negedge clock);
		`CHK(dataOe, 8'h00)
		u_cpr_fpga_model.setInit(1'b1);
		repeat (3) @(negedge clock);
		for (int i = 0; i < 4; i++) begin
			if (i > 0)
				u_cpr_fpga_model.step();
			`CHK({dataOe, dataOut}, {8'hFF, mem[i]})
		end
	endtask
	task automatic t_select();
		chipSelectN = 1'b1;
		repeat (3) @(negedge clock);
		`CHK({dataOe, standby}, {8'h00, 1'b1})
		u_cpr_fpga_model.setInit(1'b0);
		repeat (2) @(negedge clock);
		`CHK({dataOe, standby, chain_enable_out_n}, {8'h00, 1'b1, 1'b1})
		u_cpr_fpga_model.setInit(1'b1);
		chipSelectN = 1'b0;
		repeat (4) @(negedge clock);
		`CHK({standby, dataOe, dataOut}, {1'b0, 8'hFF, mem[0]})
	endtask
	task automatic t_strobe();
		logic [7:0] codes [8] = '{8'hFF, 8'h01, 8'h00, 8'hFA, 8'hFC, 8'hFE, 8'hFD, 8'hEE};
		int low;
		foreach (codes[k]) begin
			instrCode = codes[k];
			instrUpdate = 1'b1;
			@(negedge clock);
			instrUpdate = 1'b0;
			low = 0;
			repeat (12) begin
				@(negedge clock);
				low += (fpga_config_strobe_n !== 1'b1);
			end
			`CHK(low, codes[k] == INSTR_LAUNCH_CONFIG ? 8 : 0)
		end
	endtask
	task automatic t_done();
		for (int i = 1; i < 4; i++)
			u_cpr_fpga_model.step();
		`CHK({chain_enable_out_n, dataOe, dataOut}, {1'b1, 8'hFF, mem[3]})
		u_cpr_fpga_model.step();
		`CHK({chain_enable_out_n, dataOe}, {1'b0, 8'h00})
		u_cpr_fpga_model.step();
		`CHK({chain_enable_out_n, dataOe}, {1'b0, 8'h00})
		u_cpr_fpga_model.setInit(1'b0);
		repeat (2) @(negedge clock);
		`CHK({chain_enable_out_n, dataOe}, {1'b1, 8'h00})
		u_cpr_fpga_model.setInit(1'b1);
		repeat (3) @(negedge clock);
		`CHK({dataOe, dataOut}, {8'hFF, mem[0]})
	endtask
	task automatic t_freeze();
		int low;
		low = 0;
		clkEn = 1'b0;
		instrCode = INSTR_LAUNCH_CONFIG;
		instrUpdate = 1'b1;
		@(negedge clock);
		instrUpdate = 1'b0;
		repeat (12) begin
			@(negedge clock);
			low += (fpga_config_strobe_n !== 1'b1);
		end
		`CHK(low, 0)
		u_cpr_fpga_model.step();
		`CHK({dataOe, dataOut}, {8'hFF, mem[0]})
		clkEn = 1'b1;
		u_cpr_fpga_model.step();
		`CHK({dataOe, dataOut}, {8'hFF, mem[1]})
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		clkEn = 1'b1;
		chipSelectN = 1'b0;
		instrUpdate = 1'b0;
		instrCode = 8'h00;
		userCtrlWrite = 1'b0;
		userCtrlParallel = 1'b0;
		progWrite = 1'b0;
		progAddr = '0;
		progData = 8'h00;
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		t_powerup();
		for (int a = 0; a < 4; a++)
			prog(ADDR_W'(a), mem[a]);
		t_serial();
		t_parallel();
		t_select();
		t_done();
		t_freeze();
		t_strobe();
		results();
	end
endmodule // cpr_readout_test

bind cpr_readout cpr_readout_checker #(.POWERUP_HOLD_CYCLES(POWERUP_HOLD_CYCLES)) u_cpr_readout_checker (
	.clock, .sys_rst, .clkEn, .config_clock, .resetOeN, .chipSelectN, .dataOut, .dataOe, .chain_enable_out_n,
	.resetOeOut, .resetOeOe, .fpga_config_strobe_n, .standby, .instrCode, .instrUpdate);
`default_nettype wire
